// ### src/csg_pkg.sv
// package for the output shutdown and capture gating control block
package csg_pkg;

  // ------------------------------------------------------------
  // register word addresses (plain port, word index)
  // ------------------------------------------------------------
  localparam logic [3:0] CSG_ADDR_STEER = 4'h0;
  localparam logic [3:0] CSG_ADDR_DEAD = 4'h1;
  localparam logic [3:0] CSG_ADDR_MODE = 4'h2;
  localparam logic [3:0] CSG_ADDR_SRC = 4'h3;
  localparam logic [3:0] CSG_ADDR_STAT = 4'h4;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CSG_RST_WORD = 16'h0000;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CSG_SYNC_BIT = 15;
  localparam int CSG_STEER_LO = 8;
  localparam int CSG_GATE_LO = 6;
  localparam int CSG_AUX_LO = 3;
  localparam int CSG_ICS_LO = 0;
  localparam int CSG_HOLD_BIT = 15;
  localparam int CSG_OSC_LO = 12;
  localparam int CSG_PWM_OUTPUT_MODE_LO = 8;
  localparam int CSG_POL1_BIT = 5;
  localparam int CSG_POL2_BIT = 4;
  localparam int CSG_PSS1_LO = 2;
  localparam int CSG_PSS2_LO = 0;
  localparam int CSG_ARM_BIT = 10;
  localparam int CSG_SHUTDOWN_EVENT_STATUS_BIT = 4;
  localparam int CSG_CAPTURE_DISABLE_STATUS_BIT = 2;

  // writable masks per variant
  localparam logic [15:0] CSG_STEER_MASK_MULTI = 16'hBFDF;
  localparam logic [15:0] CSG_STEER_MASK_SINGLE = 16'h81DF;
  localparam logic [15:0] CSG_DEAD_MASK = 16'h003F;
  localparam logic [15:0] CSG_MODE_MASK_MULTI = 16'hF73F;
  localparam logic [15:0] CSG_MODE_MASK_SINGLE = 16'hF02C;

  // ------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------
  localparam logic [1:0] CSG_GATE_LEVEL = 2'h0;
  localparam logic [1:0] CSG_GATE_RISE = 2'h1;
  localparam logic [1:0] CSG_GATE_FALL = 2'h2;
  localparam logic [1:0] CSG_AUX_OFF = 2'h0;
  localparam logic [1:0] CSG_AUX_ROLL = 2'h1;
  localparam logic [1:0] CSG_AUX_MODE = 2'h2;
  localparam logic [2:0] CSG_PWM_OUTPUT_MODE_SINGLE = 3'h0;
  localparam logic [2:0] CSG_PWM_OUTPUT_MODE_PUSHPULL = 3'h1;
  localparam logic [2:0] CSG_PWM_OUTPUT_MODE_HALF = 3'h2;
  localparam logic [2:0] CSG_PWM_OUTPUT_MODE_BDC_REV = 3'h4;
  localparam logic [2:0] CSG_PWM_OUTPUT_MODE_BDC_FWD = 3'h5;
  localparam logic [2:0] CSG_PWM_OUTPUT_MODE_SCAN = 3'h6;

  typedef enum logic [2:0] {
    CSG_DT_IDLE = 3'b001,
    CSG_DT_WAIT = 3'b010,
    CSG_DT_RUN = 3'b100
  } csg_dt_state_t;

endpackage

// ### src/csg_ctl.sv
// output steering, shutdown, dead time and capture gating control
`timescale 1ns/1ps

// How it works
// - source enable bit 0 comparator1, 1 comparator2, 2-3 faults C/D, 4 capture, 5 cell, 6-7 faults A/B
// - sources four to seven arrive already routed through the pin remap network
// - with sync set, steering changes apply at next rollover, else immediately
// - set steering bit drives that pin with the compare signal, clear releases it
// - steering bits B to F exist only in the multi-output variant
// - gate mode 10: falling gate edge sets capture disable
// - gate mode 01: rising gate edge clears capture disable
// - gate mode 00 follows gate level; mode 11 reserved, holds capture disable and clears any arm
// - aux select: off, rollover, mode signal, capture/compare event unless plain timer
// - capture source select: pin, comparators one to three, logic cells one to four
// - nonzero dead time N delays each complementary rising edge N periods; zero disables
// - dead time register exists only in the multi-output variant
// - trigger hold with triggered operation releases pins until trigger occurs
// - one-shot extend N stretches trigger to N plus one time base periods
// - output mode selects single, push-pull, half-bridge, brush DC, scan; others reserved
// - polarity bits make groups ACE and BDF active low when set
// - shutdown state 11 active, 10 inactive, 0x high impedance per group
// - BDF polarity, output mode and BDF shutdown state only in multi variant
// - enabled sources trigger shutdown or gating, disabled ones are ignored
// - capture disable status blocks capture events while set
// - write-only arm bit arms one-shot gating once, reads back zero
// - outside trigger hold, shutdown status set forces the steered outputs to their shutdown states
module csg_ctl import csg_pkg::*; #(
  parameter bit MULTI = 1'b1
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // time base and engine signals
  input wire logic tb_rollover_in,
  input wire logic tb_tick_in,
  input wire logic pwm_in,
  input wire logic mode_aux_in,
  input wire logic cc_event_in,
  input wire logic timer_mode_in,
  input wire logic triggered_operation_enable_in,
  input wire logic trigger_in,
  input wire logic shutdown_clear_in,
  // shutdown and capture sources
  input wire logic comparator_one_in,
  input wire logic comparator_two_in,
  input wire logic comparator_three_in,
  input wire logic fault_input_a_in,
  input wire logic fault_input_b_in,
  input wire logic fault_input_c_in,
  input wire logic fault_input_d_in,
  input wire logic own_capture_input_in,
  input wire logic capture_input_pin_in,
  input wire logic [3:0] logic_cell_outputs_in,
  // outputs
  output logic [5:0] compare_output_pin_out,
  output logic [5:0] compare_output_oe_out,
  output logic capture_event_out,
  output logic aux_out,
  output logic trigger_active_out,
  output logic shutdown_event_status_out,
  output logic capture_disable_status_out
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] steer_reg;
  logic [15:0] dead_reg;
  logic [15:0] mode_reg;
  logic [7:0] shutdown_source_enables_reg;
  logic [5:0] steer_live_reg;
  logic steer_pend_reg;
  logic capture_disable_reg;
  logic shutdown_reg;
  logic armed_reg;
  logic gate_prev_reg;
  logic cap_prev_reg;
  logic [2:0] shot_cnt_reg;
  logic shot_reg;
  logic held_reg;
  logic [5:0] dt_cnt_reg;
  logic dt_a_reg;
  logic dt_b_reg;
  logic pwm_prev_reg;
  csg_dt_state_t dt_state_reg;
  csg_dt_state_t dt_state_next;

  // masks that hide bits missing in the single-output variant
  wire logic [15:0] steer_mask = MULTI ? CSG_STEER_MASK_MULTI : CSG_STEER_MASK_SINGLE;
  wire logic [15:0] dead_mask = MULTI ? CSG_DEAD_MASK : CSG_RST_WORD;
  wire logic [15:0] mode_mask = MULTI ? CSG_MODE_MASK_MULTI : CSG_MODE_MASK_SINGLE;

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  wire logic wr_steer = reg_wr_in && reg_addr_in == CSG_ADDR_STEER;
  wire logic wr_dead = reg_wr_in && reg_addr_in == CSG_ADDR_DEAD;
  wire logic wr_mode = reg_wr_in && reg_addr_in == CSG_ADDR_MODE;
  wire logic wr_src = reg_wr_in && reg_addr_in == CSG_ADDR_SRC;
  wire logic arm_strobe = reg_wr_in && reg_addr_in == CSG_ADDR_STAT && reg_wdata_in[CSG_ARM_BIT];
  wire logic [15:0] stat_word = {11'h000, shutdown_reg, 1'b0, capture_disable_reg, 2'h0};
  // unmapped and unimplemented bits read zero
  wire logic [15:0] rd_word =
    reg_addr_in == CSG_ADDR_STEER ? steer_reg :
    reg_addr_in == CSG_ADDR_DEAD ? dead_reg :
    reg_addr_in == CSG_ADDR_MODE ? mode_reg :
    reg_addr_in == CSG_ADDR_SRC ? {8'h00, shutdown_source_enables_reg} :
    reg_addr_in == CSG_ADDR_STAT ? stat_word : CSG_RST_WORD;

  // ------------------------------------------------------------
  // field extraction
  // ------------------------------------------------------------
  wire logic steer_update_sync = steer_reg[CSG_SYNC_BIT];
  wire logic [5:0] pin_steer_enables = steer_reg[CSG_STEER_LO +: 6];
  wire logic [1:0] capture_gate_mode = steer_reg[CSG_GATE_LO +: 2];
  wire logic [1:0] aux_event_select = steer_reg[CSG_AUX_LO +: 2];
  wire logic [2:0] capture_source_select = steer_reg[CSG_ICS_LO +: 3];
  wire logic [5:0] dead_time_count = dead_reg[5:0];
  wire logic output_trigger_hold = mode_reg[CSG_HOLD_BIT];
  wire logic [2:0] one_shot_extend = mode_reg[CSG_OSC_LO +: 3];
  wire logic [2:0] pwm_output_mode = mode_reg[CSG_PWM_OUTPUT_MODE_LO +: 3];
  wire logic polarity_group_one = mode_reg[CSG_POL1_BIT];
  wire logic polarity_group_two = mode_reg[CSG_POL2_BIT];
  wire logic [1:0] shutdown_state_group_one = mode_reg[CSG_PSS1_LO +: 2];
  wire logic [1:0] shutdown_state_group_two = mode_reg[CSG_PSS2_LO +: 2];

  // ------------------------------------------------------------
  // source maps
  // ------------------------------------------------------------
  // fixed shutdown source order; bits 4-7 come pre-routed from the remap network
  wire logic [7:0] shutdown_sources = {fault_input_b_in, fault_input_a_in, logic_cell_outputs_in[0],
    own_capture_input_in, fault_input_d_in, fault_input_c_in, comparator_two_in, comparator_one_in};
  wire logic gate_src = |(shutdown_sources & shutdown_source_enables_reg);
  wire logic [7:0] capture_sources = {logic_cell_outputs_in, comparator_three_in, comparator_two_in,
    comparator_one_in, capture_input_pin_in};
  wire logic cap_src = capture_sources[capture_source_select];

  // ------------------------------------------------------------
  // gating edges and capture
  // ------------------------------------------------------------
  wire logic gate_rise = gate_src && !gate_prev_reg;
  wire logic gate_fall = !gate_src && gate_prev_reg;
  wire logic capture_next = cap_src && !cap_prev_reg && !capture_disable_reg;

  // capture disable status; a gate edge wins over the arm write
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      capture_disable_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      case (capture_gate_mode)
        CSG_GATE_LEVEL: begin
          capture_disable_reg <= !gate_src;
          armed_reg <= 1'b0;
        end
        // rising edge re-enables capture once armed
        CSG_GATE_RISE: begin
          if (armed_reg && gate_rise) begin
            capture_disable_reg <= 1'b0;
            armed_reg <= 1'b0;
          end else if (arm_strobe) begin
            armed_reg <= 1'b1;
          end
        end
        // falling edge disables capture once armed
        CSG_GATE_FALL: begin
          if (armed_reg && gate_fall) begin
            capture_disable_reg <= 1'b1;
            armed_reg <= 1'b0;
          end else if (arm_strobe) begin
            armed_reg <= 1'b1;
          end
        end
        default: armed_reg <= 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // masks drop writes to absent bits
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      steer_reg <= CSG_RST_WORD;
      dead_reg <= CSG_RST_WORD;
      mode_reg <= CSG_RST_WORD;
      shutdown_source_enables_reg <= 8'h00;
    end else begin
      if (wr_steer) steer_reg <= reg_wdata_in & steer_mask;
      if (wr_dead) dead_reg <= reg_wdata_in & dead_mask;
      if (wr_mode) mode_reg <= reg_wdata_in & mode_mask;
      if (wr_src) shutdown_source_enables_reg <= reg_wdata_in[7:0];
    end
  end

  // steering takes effect now or at the next rollover
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      steer_live_reg <= 6'h00;
      steer_pend_reg <= 1'b0;
    end else if (!steer_update_sync || (steer_pend_reg && tb_rollover_in)) begin
      steer_live_reg <= pin_steer_enables;
      steer_pend_reg <= wr_steer;
    end else if (wr_steer) begin
      steer_pend_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // shutdown, one-shot and trigger hold
  // ------------------------------------------------------------
  // shutdown holds until the engine clears it and no source is active
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) shutdown_reg <= 1'b0;
    else if (gate_src) shutdown_reg <= 1'b1;
    else if (shutdown_clear_in) shutdown_reg <= 1'b0;
  end

  // stretch a trigger over one_shot_extend extra periods
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shot_reg <= 1'b0;
      shot_cnt_reg <= 3'h0;
      held_reg <= 1'b0;
    end else begin
      if (trigger_in) begin
        shot_reg <= 1'b1;
        shot_cnt_reg <= one_shot_extend;
      end else if (shot_reg && tb_rollover_in) begin
        if (shot_cnt_reg == 3'h0) shot_reg <= 1'b0;
        else shot_cnt_reg <= shot_cnt_reg - 3'h1;
      end
      // pins stay undriven until the first trigger
      if (!triggered_operation_enable_in) held_reg <= 1'b0;
      else if (trigger_in) held_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // dead time
  // ------------------------------------------------------------
  // count dead-time ticks after each pwm edge
  always_comb begin
    dt_state_next = dt_state_reg;
    case (dt_state_reg)
      CSG_DT_IDLE: if (dead_time_count != 6'h00) dt_state_next = CSG_DT_RUN;
      CSG_DT_RUN: if (pwm_in != pwm_prev_reg) dt_state_next = CSG_DT_WAIT;
      CSG_DT_WAIT: if (dt_cnt_reg == 6'h00) dt_state_next = CSG_DT_RUN;
      default: dt_state_next = CSG_DT_IDLE;
    endcase
    if (dead_time_count == 6'h00) dt_state_next = CSG_DT_IDLE;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dt_state_reg <= CSG_DT_IDLE;
      dt_cnt_reg <= 6'h00;
      pwm_prev_reg <= 1'b0;
      dt_a_reg <= 1'b0;
      dt_b_reg <= 1'b0;
    end else begin
      dt_state_reg <= dt_state_next;
      pwm_prev_reg <= pwm_in;
      if (dt_state_next == CSG_DT_WAIT && dt_state_reg == CSG_DT_RUN) dt_cnt_reg <= dead_time_count;
      else if (tb_tick_in && dt_cnt_reg != 6'h00) dt_cnt_reg <= dt_cnt_reg - 6'h1;
      // both sides low during the gap, zero count bypasses it
      dt_a_reg <= dt_state_next == CSG_DT_RUN ? pwm_in : (dt_state_next == CSG_DT_IDLE && pwm_in);
      dt_b_reg <= dt_state_next == CSG_DT_RUN ? !pwm_in : (dt_state_next == CSG_DT_IDLE && !pwm_in);
    end
  end

  // ------------------------------------------------------------
  // output steering by mode
  // ------------------------------------------------------------
  // mode picks which active level each pin carries
  logic [5:0] act;
  always_comb begin
    act = 6'h00;
    case (pwm_output_mode)
      CSG_PWM_OUTPUT_MODE_SINGLE: act = {6{pwm_in}};
      CSG_PWM_OUTPUT_MODE_PUSHPULL: act = {4'h0, !pwm_in && shot_reg, pwm_in && shot_reg};
      CSG_PWM_OUTPUT_MODE_HALF: act = {4'h0, dt_b_reg, dt_a_reg};
      CSG_PWM_OUTPUT_MODE_BDC_REV: act = {4'h0, 1'b1, pwm_in};
      CSG_PWM_OUTPUT_MODE_BDC_FWD: act = {3'h0, 1'b1, 1'b0, pwm_in};
      CSG_PWM_OUTPUT_MODE_SCAN: act = {pwm_in, 5'h00};
      default: act = 6'h00;
    endcase
  end

  wire logic [5:0] pol = {polarity_group_two, polarity_group_one, polarity_group_two,
    polarity_group_one, polarity_group_two, polarity_group_one};
  wire logic [5:0] sd_hi = {3{shutdown_state_group_two[1], shutdown_state_group_one[1]}};
  wire logic [5:0] sd_act = {3{shutdown_state_group_two[0], shutdown_state_group_one[0]}};
  wire logic hold_now = output_trigger_hold && triggered_operation_enable_in && !held_reg;
  // drive only steered pins, shutdown states override
  wire logic [5:0] pin_next = (shutdown_reg ? sd_act : act) ^ pol;
  wire logic [5:0] oe_next = hold_now ? 6'h00 : (shutdown_reg ? steer_live_reg & sd_hi : steer_live_reg);

  wire logic aux_next =
    aux_event_select == CSG_AUX_OFF ? 1'b0 :
    aux_event_select == CSG_AUX_ROLL ? tb_rollover_in :
    aux_event_select == CSG_AUX_MODE ? mode_aux_in : cc_event_in && !timer_mode_in;

  // ------------------------------------------------------------
  // output flops
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= CSG_RST_WORD;
      compare_output_pin_out <= 6'h00;
      compare_output_oe_out <= 6'h00;
      capture_event_out <= 1'b0;
      aux_out <= 1'b0;
      gate_prev_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_word : CSG_RST_WORD;
      compare_output_pin_out <= pin_next;
      compare_output_oe_out <= oe_next;
      capture_event_out <= capture_next;
      aux_out <= aux_next;
      gate_prev_reg <= gate_src;
      cap_prev_reg <= cap_src;
    end
  end

  assign trigger_active_out = shot_reg;
  assign shutdown_event_status_out = shutdown_reg;
  assign capture_disable_status_out = capture_disable_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // outside trigger hold, shutdown drives steered pins only where the shutdown state is 1x
  shutdown_oe_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    shutdown_reg && !hold_now |=> compare_output_oe_out == ($past(steer_live_reg) & $past(sd_hi)))
    else $error("shutdown enable mismatch");
  capture_block_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    capture_disable_reg |=> !capture_event_out)
    else $error("capture while disabled");
  gate_level_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    capture_gate_mode == CSG_GATE_LEVEL && $stable(capture_gate_mode) |=> capture_disable_reg == !$past(gate_src))
    else $error("level gating wrong");
  gate_fall_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    capture_gate_mode == CSG_GATE_FALL && armed_reg && gate_fall |=> capture_disable_reg && !armed_reg)
    else $error("fall gating wrong");
  gate_rise_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    capture_gate_mode == CSG_GATE_RISE && armed_reg && gate_rise |=> !capture_disable_reg)
    else $error("rise gating wrong");
  steer_now_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    !steer_update_sync |=> steer_live_reg == $past(pin_steer_enables))
    else $error("steering not immediate");
  arm_read_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    reg_rd_in && reg_addr_in == CSG_ADDR_STAT |=> !reg_rdata_out[CSG_ARM_BIT])
    else $error("arm bit reads one");
  trig_hold_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    hold_now |=> compare_output_oe_out == 6'h00)
    else $error("pins driven before trigger");
  // dead gap keeps both outputs low
  dead_gap_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    dt_state_reg == CSG_DT_WAIT |-> !(dt_a_reg || dt_b_reg))
    else $error("dead gap overlap");

endmodule

// ### verification/csg_far_model.sv
// far-side model: shutdown and capture sources, output pin wires
`timescale 1ns/1ps
module csg_far_model (
  // clock
  input wire logic core_clk_in,
  // commanded source levels and block pins
  input wire logic [12:0] src_cmd_in,
  input wire logic [5:0] pin_in,
  input wire logic [5:0] oe_in,
  // what the block and the bench see
  output logic [12:0] src_out,
  output logic [5:0] pin_seen_out
);
  logic [5:0] float_reg = 6'h15;
  // remapped sources
  // levels move one edge after the command, as through the pin remap network
  always_ff @(posedge core_clk_in) begin
    src_out <= src_cmd_in;
    float_reg <= ~float_reg;
  end
  // a released pin has no pull, so it toggles instead of keeping a stale level
  assign pin_seen_out = (pin_in & oe_in) | (float_reg & ~oe_in);
endmodule

// ### verification/tb.sv
// self-checking bench for the shutdown and capture gating control block
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0, rd = 1'b0, roll = 1'b0, tick = 1'b0, pwm = 1'b0, maux = 1'b0;
  logic cce = 1'b0, tmode = 1'b0, tren = 1'b0, trig = 1'b0, sclr = 1'b0;
  logic [12:0] src_cmd = 13'h0000;
  logic [12:0] src;
  logic [15:0] rdata;
  logic [5:0] pin, oe, pin_seen;
  logic cap_ev, aux, trig_act, sd_stat, cap_dis;
  logic [3:0] a4;
  logic [15:0] d;
  int err_total = 0;
  int n_compared = 0;
  int n_cap = 0, n_aux = 0, n0 = 0, n = 0;
  int cap_pos [8] = '{9, 0, 1, 8, 5, 10, 11, 12};

  always #5 core_clk = ~core_clk;

  // capture pulses stand one cycle, aux as long as its input; count them at every edge, an unknown counts too
  always @(posedge core_clk) begin
    if (cap_ev !== 1'b0) n_cap <= n_cap + 1;
    if (aux !== 1'b0) n_aux <= n_aux + 1;
  end

  csg_far_model u_far (.core_clk_in(core_clk), .src_cmd_in(src_cmd), .pin_in(pin), .oe_in(oe),
    .src_out(src), .pin_seen_out(pin_seen));
  csg_ctl #(.MULTI(1'b1)) u_dut (.core_clk_in(core_clk), .resetn_in(resetn), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .tb_rollover_in(roll),
    .tb_tick_in(tick), .pwm_in(pwm), .mode_aux_in(maux), .cc_event_in(cce), .timer_mode_in(tmode),
    .triggered_operation_enable_in(tren), .trigger_in(trig), .shutdown_clear_in(sclr),
    .comparator_one_in(src[0]), .comparator_two_in(src[1]), .comparator_three_in(src[8]),
    .fault_input_a_in(src[6]), .fault_input_b_in(src[7]), .fault_input_c_in(src[2]),
    .fault_input_d_in(src[3]), .own_capture_input_in(src[4]), .capture_input_pin_in(src[9]),
    .logic_cell_outputs_in({src[12:10], src[5]}), .compare_output_pin_out(pin),
    .compare_output_oe_out(oe), .capture_event_out(cap_ev), .aux_out(aux), .trigger_active_out(trig_act),
    .shutdown_event_status_out(sd_stat), .capture_disable_status_out(cap_dis));

  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // sources pass the far-side flop, the edge detector and the status flop
  task automatic settle();
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  // rollover for one cycle, mode signal for two, event for three: the count tells which got through
  task automatic aux_try(input logic [1:0] sel, input logic tm, input int exp);
    int n1;
    wr_reg(4'h0, {11'h000, sel, 3'h0});
    tmode <= tm;
    n1 = n_aux;
    @(posedge core_clk) roll <= 1'b1;
    @(posedge core_clk) roll <= 1'b0;
    maux <= 1'b1;
    repeat (2) @(posedge core_clk);
    maux <= 1'b0;
    cce <= 1'b1;
    repeat (3) @(posedge core_clk);
    cce <= 1'b0;
    settle();
    chk(16'(n_aux - n1), 16'(exp));
  endtask
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic logic [15:0] mask_of(input logic [3:0] a);
    case (a)
      4'h0: return 16'hBFDF;
      4'h1: return 16'h003F;
      4'h2: return 16'hF73F;
      4'h3: return 16'h00FF;
      default: return 16'h0000;
    endcase
  endfunction
  // expected {enable, level} of pin A; level reads zero when the pin is released
  function automatic logic [1:0] pin_a(input logic p, input logic pol, input logic sd, input logic [1:0] pss);
    if (!sd) return {1'b1, p ^ pol};
    if (!pss[1]) return 2'b00;
    return {1'b1, pss[0] ^ pol};
  endfunction

  // watchdog sized well above the expected run of a few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    summarize();
  end

  initial begin
    void'($urandom(32'hDBBAEAED));
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      if (a != 4) rd_chk(4'(a), 16'h0000);
    end
    for (int i = 0; i < 16; i++) begin
      a4 = 4'($urandom_range(3));
      d = 16'($urandom);
      wr_reg(a4, d);
      rd_chk(a4, d & mask_of(a4));
    end
    wr_reg(4'h5, 16'hFFFF);
    rd_chk(4'h5, 16'h0000);
    for (int a = 0; a < 4; a++) wr_reg(4'(a), 16'h0000);
    $display("test registers done");
    // level gating: only the enabled source may open the gate
    for (int i = 0; i < 8; i++) begin
      wr_reg(4'h3, 16'(1 << i));
      @(posedge core_clk) src_cmd <= 13'(1 << i);
      settle();
      chk(16'(cap_dis), 16'h0000);
      @(posedge core_clk) src_cmd <= 13'h1FFF ^ 13'(1 << i);
      settle();
      chk(16'(cap_dis), 16'h0001);
    end
    $display("test source map done");
    wr_reg(4'h3, 16'h0001);
    @(posedge core_clk) src_cmd <= 13'h0001;
    settle();
    chk(16'(cap_dis), 16'h0000);
    wr_reg(4'h0, 16'h0080);
    wr_reg(4'h4, 16'h0400);
    @(posedge core_clk) src_cmd <= 13'h0000;
    settle();
    chk(16'(cap_dis), 16'h0001);
    wr_reg(4'h0, 16'h0040);
    wr_reg(4'h4, 16'h0400);
    @(posedge core_clk) src_cmd <= 13'h0001;
    settle();
    chk(16'(cap_dis), 16'h0000);
    wr_reg(4'h0, 16'h0080);
    @(posedge core_clk) src_cmd <= 13'h0000;
    settle();
    chk(16'(cap_dis), 16'h0000);
    $display("test one-shot gating done");
    // steering, polarity and shutdown states on pin A, fault A as shutdown source
    wr_reg(4'h3, 16'h0040);
    wr_reg(4'h0, 16'h0100);
    @(posedge core_clk) sclr <= 1'b1;
    @(posedge core_clk) sclr <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      @(posedge core_clk) src_cmd <= {6'h00, k[3], 6'h00};
      pwm <= 1'($urandom);
      wr_reg(4'h2, {10'h000, k[2], 1'b0, k[1:0], 2'b00});
      settle();
      chk(16'(sd_stat), 16'(k[3]));
      chk({14'h0000, oe[0], oe[0] & pin_seen[0]}, 16'(pin_a(pwm, k[2], k[3], 2'(k[1:0]))));
    end
    @(posedge core_clk) src_cmd <= 13'h0000;
    @(posedge core_clk) sclr <= 1'b1;
    @(posedge core_clk) sclr <= 1'b0;
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h4, 16'h0400);
    settle();
    rd_chk(4'h4, 16'h0004);
    $display("test pins and shutdown done");
    wr_reg(4'h0, 16'h8100);
    settle();
    chk(16'(oe[0]), 16'h0000);
    @(posedge core_clk) roll <= 1'b1;
    @(posedge core_clk) roll <= 1'b0;
    settle();
    chk(16'(oe[0]), 16'h0001);
    $display("test synchronized steering done");
    // fault C holds the level gate open; each selected source captures once
    wr_reg(4'h3, 16'h0004);
    @(posedge core_clk) src_cmd <= 13'h0004;
    for (int s = 0; s < 8; s++) begin
      wr_reg(4'h0, 16'(s));
      n0 = n_cap;
      @(posedge core_clk) src_cmd <= 13'h0004 | (13'h0001 << cap_pos[s]);
      settle();
      chk(16'(n_cap - n0), 16'h0001);
    end
    @(posedge core_clk) src_cmd <= 13'h0000;
    settle();
    @(posedge core_clk) src_cmd <= 13'h1000;
    settle();
    chk(16'(n_cap - n0), 16'h0001);
    $display("test capture source done");
    // trigger hold releases steered pins until a trigger, then the one-shot stretch
    wr_reg(4'h3, 16'h0000);
    wr_reg(4'h0, 16'h0100);
    wr_reg(4'h2, 16'h8000);
    @(posedge core_clk) sclr <= 1'b1;
    tren <= 1'b1;
    @(posedge core_clk) sclr <= 1'b0;
    settle();
    chk(16'(oe[0]), 16'h0000);
    @(posedge core_clk) trig <= 1'b1;
    @(posedge core_clk) trig <= 1'b0;
    settle();
    chk(16'(oe[0]), 16'h0001);
    n = $urandom_range(7);
    wr_reg(4'h2, {1'b0, 3'(n), 12'h000});
    @(posedge core_clk) trig <= 1'b1;
    @(posedge core_clk) trig <= 1'b0;
    for (int r = 0; r <= n; r++) begin
      #1;
      chk(16'(trig_act), 16'h0001);
      @(posedge core_clk) roll <= 1'b1;
      @(posedge core_clk) roll <= 1'b0;
    end
    #1;
    chk(16'(trig_act), 16'h0000);
    $display("test trigger done");
    aux_try(2'h0, 1'b0, 0);
    aux_try(2'h1, 1'b0, 1);
    aux_try(2'h2, 1'b0, 2);
    aux_try(2'h3, 1'b0, 3);
    aux_try(2'h3, 1'b1, 0);
    $display("test aux events done");
    summarize();
  end
endmodule
